// [hw/mrs_pkg.sv]
/*
 * constants shared by the receive and line-status input block
 * assumes a 100 MHz core clock and a slower link receive clock
 */
package mrs_pkg;

    // ************************************************************
    // data path widths
    // ************************************************************
    localparam int NIB_W      = 4;          // nibble width on the link
    localparam int FIFO_DEPTH = 8;          // words in the data buffer
    localparam int SYNC_W     = 5;          // clk, dv, er, crs, col
    // bit positions inside the synchroniser vector
    localparam int SB_CLK     = 0;
    localparam int SB_DV      = 1;
    localparam int SB_ER      = 2;
    localparam int SB_CRS     = 3;
    localparam int SB_COL     = 4;
    // buffered word: error flag above the nibble
    localparam int WORD_W     = NIB_W + 1;
    localparam int WB_ERR     = NIB_W;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [SYNC_W-1:0] SYNC_RST = 5'h00;
    localparam logic [NIB_W-1:0]  NIB_RST  = 4'h0;

    // frame tracking states, one bit flips per step except ended back to idle
    typedef enum logic [1:0]
    {
        MRS_IDLE  = 2'h0,
        MRS_FRAME = 2'h1,
        MRS_ENDED = 2'h3
    } mrs_state_e;

endpackage

// [hw/mrs_fifo.sv]
/*
 * small synchronous fifo with valid/ready on both sides
 * assumes one clock; full and empty reflect true occupancy
 */
`timescale 1ns/1ps

module mrs_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);

    localparam int AW = $clog2(DEPTH);

    // ************************************************************
    // storage and pointers
    // ************************************************************
    logic [WIDTH-1:0] mem [DEPTH];          // word array
    logic [AW-1:0]    wr_q;                 // write pointer
    logic [AW-1:0]    rd_q;                 // read pointer
    logic [AW:0]      cnt_q;                // occupancy
    logic             push;
    logic             pop;

    // ready until every slot holds a word
    assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data  = mem[rd_q];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    // pointer wrap helper
    function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
        begin
            nxt = (p == AW'(DEPTH-1)) ? '0 : p + 1'b1;
        end
    endfunction

    // ************************************************************
    // pointer and count update
    // ************************************************************
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= nxt(wr_q);
            if (pop)
                rd_q <= nxt(rd_q);
            // count moves only when one side acts alone
            if (push && !pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop && !push)
                cnt_q <= cnt_q - 1'b1;
        end
    end

    // data array, no reset needed
    always_ff @(posedge i_clk)
    begin
        if (push)
            mem[wr_q] <= i_in_data;
    end

endmodule

// [hw/mrs_rx_inputs.sv]
/*
 * receive data, error flag, carrier sense and collision inputs of the
 * media independent interface, seen from inside the mac.
 * assumes the phy drives all link pins; the receive clock is sampled
 * as data by the core clock, so it must be well below half its rate.
 */
`timescale 1ns/1ps

module mrs_rx_inputs
    import mrs_pkg::*;
#(
    parameter int FIFO_D = FIFO_DEPTH
) (
    input  wire logic                     I_CORE_CLK,
    input  wire logic                     I_RESET,
    input  wire logic                     I_RX_CLK,
    input  wire logic                     I_RX_DV,
    input  wire logic                     I_RX_ER,
    input  wire logic [mrs_pkg::NIB_W-1:0] I_RXD,
    input  wire logic                     I_CRS,
    input  wire logic                     I_COL,
    input  wire logic                     I_SERIAL_CODEC_MODE,
    input  wire logic                     I_FULL_DUPLEX,
    input  wire logic                     I_DATA_READY,
    output logic                          O_DATA_VALID,
    output logic [mrs_pkg::NIB_W-1:0]     O_DATA,
    output logic                          O_DATA_ERR,
    output logic                          O_FRAME_END,
    output logic                          O_OVERFLOW,
    output logic                          O_CARRIER,
    output logic                          O_COLLISION
);
    import mrs_pkg::*;

    // ************************************************************
    // limits and hazards
    // ************************************************************
    // the receive clock is sampled as data, never used as a clock:
    // a link period must span well over two core cycles, or a
    // rising edge slips between two samples and a nibble is lost.
    // the data pins ride the same two-flop path as the clock, so a
    // nibble is read at the detected edge with its setup intact.
    // carrier and collision bear no relation to any clock and are
    // only synchronised; a blip shorter than a core period may go
    // unseen, which the phy's hold rules make harmless.
    // the fifo absorbs consumer stalls; with one word waiting in the
    // output stage, nine nibbles fit before one is dropped and the
    // overflow pulse marks the loss.
    // serial mode is latched in every idle cycle, the first nibble's included,
    // so a mode change in that cycle splits a frame into two formats.

    // ************************************************************
    // state record
    // ************************************************************
    typedef struct packed {
        logic [SYNC_W-1:0] s1;          // first synchroniser stage
        logic [SYNC_W-1:0] s2;          // second synchroniser stage
        logic [NIB_W-1:0]  d1;          // data first stage
        logic [NIB_W-1:0]  d2;          // data second stage
        logic              clk_prev;    // last synced receive clock
        logic              mode_q;      // serial mode, held per frame
        mrs_state_e        st;          // frame tracking
        logic              ovf;         // overflow pulse
        logic              end_p;       // frame end pulse
        logic              crs;         // carrier output
        logic              col;         // collision output
        logic [NIB_W-1:0]  dat;         // output data
        logic              err;         // output error flag
        logic              vld;         // output valid
    } mrs_s;

    mrs_s              cur_q;           // registered state
    mrs_s              nxt_d;           // next state
    logic              f_in_ready;      // fifo can accept
    logic              f_out_valid;     // fifo holds a word
    logic [WORD_W-1:0] f_out_data;      // fifo head word
    logic              push;            // capture strobe into fifo
    logic [WORD_W-1:0] push_word;       // captured nibble and error
    logic              rise;            // receive clock rising edge
    logic              take;            // output register may load

    // ************************************************************
    // capture decode
    // ************************************************************
    // rising edge of the link clock seen through the synchroniser;
    // data was sampled alongside, so it is stable at this point
    assign rise = cur_q.s2[SB_CLK] && !cur_q.clk_prev;
    // one nibble per link clock with data-valid high, else ignored
    assign push = rise && cur_q.s2[SB_DV];
    // serial mode keeps only bit 0; error only counts with valid
    assign push_word = {cur_q.s2[SB_ER] && cur_q.s2[SB_DV],
                        cur_q.mode_q ? {3'h0, cur_q.d2[0]}
                                     : cur_q.d2};
    // output register reloads when empty or consumed
    // a held word also holds the fifo head, so order is kept
    assign take = !cur_q.vld || I_DATA_READY;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        // default: every field holds, pulses are cleared below
        nxt_d       = cur_q;
        // every asynchronous pin passes two flops first
        nxt_d.s1    = {I_COL, I_CRS, I_RX_ER, I_RX_DV, I_RX_CLK};
        nxt_d.s2    = cur_q.s1;
        nxt_d.d1    = I_RXD;
        nxt_d.d2    = cur_q.d1;
        nxt_d.clk_prev = cur_q.s2[SB_CLK];
        nxt_d.ovf   = push && !f_in_ready;
        nxt_d.end_p = 1'b0;
        // carrier passes untouched in both modes
        nxt_d.crs   = cur_q.s2[SB_CRS];
        // collision masked in full duplex, same in both modes
        nxt_d.col   = cur_q.s2[SB_COL] && !I_FULL_DUPLEX;
        // output stage fed from the buffer head
        if (take)
        begin
            nxt_d.vld = f_out_valid;
            nxt_d.dat = f_out_data[NIB_W-1:0];
            nxt_d.err = f_out_data[WB_ERR];
        end
        // frame tracking on link clock edges
        case (cur_q.st)
            // waiting for the first valid nibble of a frame
            MRS_IDLE:
            begin
                // mode latched every idle cycle; the first push still uses the value from the cycle before
                nxt_d.mode_q = I_SERIAL_CODEC_MODE;
                if (push)
                    nxt_d.st = MRS_FRAME;
            end
            // inside a frame until data-valid is seen low
            MRS_FRAME:
            begin
                if (rise && !cur_q.s2[SB_DV])
                    nxt_d.st = MRS_ENDED;
            end
            // one-cycle end pulse, then back to idle
            MRS_ENDED:
            begin
                nxt_d.end_p = 1'b1;
                nxt_d.st    = MRS_IDLE;
            end
            // unused code recovers to idle
            default:
            begin
                nxt_d.st = MRS_IDLE;
            end
        endcase
    end

    // ************************************************************
    // state register
    // ************************************************************
    // reset loads constants only; every output reads low after it
    always_ff @(posedge I_CORE_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            // flags, pulses and outputs low while reset stands
            cur_q          <= '0;
            cur_q.s1       <= SYNC_RST;
            cur_q.s2       <= SYNC_RST;
            cur_q.d1       <= NIB_RST;
            cur_q.d2       <= NIB_RST;
            cur_q.dat      <= NIB_RST;
            cur_q.st       <= MRS_IDLE;
        end
        else
        begin
            // every field advances on every core edge
            cur_q <= nxt_d;
        end
    end

    // ************************************************************
    // nibble buffer
    // ************************************************************
    // words leave in arrival order; a full buffer drops the newcomer
    // and the overflow pulse is raised instead
    mrs_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .i_clk       (I_CORE_CLK),
        .i_reset     (I_RESET),
        .i_in_valid  (push),
        .o_in_ready  (f_in_ready),
        .i_in_data   (push_word),
        .o_out_valid (f_out_valid),
        .i_out_ready (take),
        .o_out_data  (f_out_data)
    );

    // outputs straight from the state flops
    // no logic sits between these flops and the pins
    assign O_DATA_VALID = cur_q.vld;
    assign O_DATA       = cur_q.dat;
    assign O_DATA_ERR   = cur_q.err;
    assign O_FRAME_END  = cur_q.end_p;
    assign O_OVERFLOW   = cur_q.ovf;
    assign O_CARRIER    = cur_q.crs;
    assign O_COLLISION  = cur_q.col;

endmodule

// [verification/mrs_rx_inputs_asserts.sv]
/* checker: output timing of mrs_rx_inputs against its input pins
   assumes the bind below and a single core clock domain */
`timescale 1ns/1ps
module mrs_rx_inputs_asserts
    import mrs_pkg::*;
(
    input wire logic                      I_CORE_CLK,
    input wire logic                      I_RESET,
    input wire logic                      I_RX_DV,
    input wire logic                      I_CRS,
    input wire logic                      I_COL,
    input wire logic                      I_FULL_DUPLEX,
    input wire logic                      I_DATA_READY,
    input wire logic                      O_DATA_VALID,
    input wire logic [mrs_pkg::NIB_W-1:0] O_DATA,
    input wire logic                      O_DATA_ERR,
    input wire logic                      O_FRAME_END,
    input wire logic                      O_OVERFLOW,
    input wire logic                      O_CARRIER,
    input wire logic                      O_COLLISION
);
    // ********
    // timing properties
    // ********
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RESET);
    // word offered while the consumer holds off
    sequence s_stall;
        O_DATA_VALID && !I_DATA_READY;
    endsequence
    // data-valid low long enough to flush the sync path, buffer empty
    sequence s_quiet;
        (!I_RX_DV)[*8] ##0 !O_DATA_VALID;
    endsequence
    a_word_holds: assert property (s_stall |=>
        O_DATA_VALID && $stable({O_DATA, O_DATA_ERR}))
        else $error("word changed while stalled");
    a_no_push: assert property (s_quiet |=> !O_DATA_VALID)
        else $error("word without data-valid");
    a_crs_sync: assert property (!$past(I_RESET, 4) |->
        O_CARRIER == $past(I_CRS, 3)) else $error("carrier path wrong");
    a_col_sync: assert property ((!$past(I_RESET, 4) &&
        !I_FULL_DUPLEX)[*4] |-> O_COLLISION == $past(I_COL, 3))
        else $error("collision path wrong");
    a_col_mask: assert property (I_FULL_DUPLEX[*4] |-> !O_COLLISION)
        else $error("collision seen in full duplex");
    a_end_pulse: assert property (O_FRAME_END |=> !O_FRAME_END)
        else $error("frame end too long");
    a_ovf_pulse: assert property (O_OVERFLOW |=> !O_OVERFLOW)
        else $error("overflow too long");
    a_ovf_full: assert property (O_OVERFLOW |-> O_DATA_VALID)
        else $error("overflow with empty buffer");
endmodule
bind mrs_rx_inputs mrs_rx_inputs_asserts u_asserts (
    .I_CORE_CLK, .I_RESET, .I_RX_DV, .I_CRS, .I_COL, .I_FULL_DUPLEX,
    .I_DATA_READY, .O_DATA_VALID, .O_DATA, .O_DATA_ERR, .O_FRAME_END,
    .O_OVERFLOW, .O_CARRIER, .O_COLLISION);

// [verification/mrs_phy_model.sv]
/* link partner: drives the receive pins one link period at a time
   assumes the bench calls link_nib and line_idle; clock idles low */
`timescale 1ns/1ps
module mrs_phy_model
    import mrs_pkg::*;
(
    input  wire logic                 i_serial,
    output logic                      o_rx_clk,
    output logic                      o_rx_dv,
    output logic                      o_rx_er,
    output logic [mrs_pkg::NIB_W-1:0] o_rxd,
    output logic                      o_crs
);
    // ********
    // pin driving
    // ********
    // quiet line at time zero, link clock stands still
    initial
    begin
        o_rx_clk = 1'b0;
        o_rx_dv  = 1'b0;
        o_rx_er  = 1'b0;
        o_rxd    = 4'hA;
        o_crs    = 1'b0;
    end
    // pins change, then the clock rises mid-period (125 ns period)
    task automatic link_nib(input logic dv, input logic er,
                            input logic [NIB_W-1:0] d);
        o_crs   = 1'b1;
        o_rx_dv = dv;
        o_rx_er = er & ~i_serial;
        o_rxd   = (dv & ~i_serial) ? d : ~o_rxd;
        if (dv & i_serial)
            o_rxd[0] = d[0];
        #62 o_rx_clk = 1'b1;
        #63 o_rx_clk = 1'b0;
    endtask
    // both media idle: carrier drops, data lines toggle, error toggles only outside serial mode
    task automatic line_idle();
        o_crs   = 1'b0;
        o_rx_dv = 1'b0;
        o_rx_er = ~o_rx_er & ~i_serial;
        o_rxd   = ~o_rxd;
    endtask
    // collision on the wire: carrier stays up for as long as it lasts
    task automatic collide(input logic c);
        o_crs   = c;
    endtask
endmodule

// [verification/testbench.sv]
/* testbench for mrs_rx_inputs: link model frames, words checked in
   order; assumes the checker binds itself from its own file */
`timescale 1ns/1ps
module testbench;
    import mrs_pkg::*;
    logic              core_clk = 1'b0; // 100 MHz core clock
    logic              reset    = 1'b1; // held at start
    logic              serial   = 1'b0; // serial codec mode
    logic              fdx      = 1'b0; // full duplex
    logic              col      = 1'b0; // collision pin
    logic              rdy      = 1'b1; // consumer ready
    logic [1:0]        rmode    = 2'h0; // 0 ready, 1 random, 2 stall
    logic              rx_clk, rx_dv, rx_er, crs;
    logic [NIB_W-1:0]  rxd, data;
    logic              valid, err, fend, ovf, carr, coll;
    logic [WORD_W-1:0] exp_q[$];        // words still expected
    logic [WORD_W-1:0] w;               // oldest note
    logic [31:0]       lfsr = 32'hA27FC43E;
    logic [31:0]       st   = 32'hA27FC43E;
    int                failures = 0;
    int                checks = 0;
    int                n_end = 0, n_ovf = 0;
    mrs_rx_inputs u_dut (
        .I_CORE_CLK(core_clk), .I_RESET(reset), .I_RX_CLK(rx_clk),
        .I_RX_DV(rx_dv), .I_RX_ER(rx_er), .I_RXD(rxd), .I_CRS(crs),
        .I_COL(col), .I_SERIAL_CODEC_MODE(serial), .I_FULL_DUPLEX(fdx),
        .I_DATA_READY(rdy), .O_DATA_VALID(valid), .O_DATA(data),
        .O_DATA_ERR(err), .O_FRAME_END(fend), .O_OVERFLOW(ovf),
        .O_CARRIER(carr), .O_COLLISION(coll));
    mrs_phy_model u_phy (.i_serial(serial), .o_rx_clk(rx_clk),
        .o_rx_dv(rx_dv), .o_rx_er(rx_er), .o_rxd(rxd), .o_crs(crs));
    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // counts a comparison, reports a mismatch at once
    task automatic compare(input string what, input logic [7:0] e,
                           input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    // one checker per kind of result: word, flag, count
    task automatic compare_word(input logic [WORD_W-1:0] e,
                                input logic [WORD_W-1:0] g);
        compare("word", {3'h0, e}, {3'h0, g});
    endtask
    task automatic compare_flag(input string what, input logic e,
                                input logic g);
        compare(what, {7'h0, e}, {7'h0, g});
    endtask
    task automatic compare_count(input string what, input int e,
                                 input int g);
        compare(what, 8'(e), 8'(g));
    endtask
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // n nibbles, the first keep noted; then a dv-low period, with error outside serial mode
    task automatic frame(input int n, input int keep);
        logic [NIB_W-1:0] d;
        logic             e;
        @(negedge core_clk);
        #2;
        for (int i = 0; i < n; i++)
        begin
            lfsr = step(lfsr);
            d = lfsr[3:0];
            e = lfsr[4] & lfsr[5];
            if (i < keep)
                exp_q.push_back({e & ~serial, serial ? {3'h0, d[0]} : d});
            u_phy.link_nib(1'b1, e, d);
            if (i == 2)
                compare_flag("carrier", 1'b1, carr);
        end
        u_phy.link_nib(1'b0, 1'b1, 4'h5);
        u_phy.line_idle();
        rmode = 2'h1;
        repeat (4) @(negedge core_clk);
        for (int k = 0; k < 300 && exp_q.size() > 0; k++)
            @(negedge core_clk);
        compare_count("queue left", 0, exp_q.size());
        compare_flag("carrier", 1'b0, carr);
    endtask
    always #5 core_clk = ~core_clk;
    // consumer ready: always, random or held off
    always @(negedge core_clk)
    begin
        st = step(st);
        rdy <= (rmode == 2'h0) | ((rmode == 2'h1) & st[0]);
    end
    // takes the oldest note whenever a word is consumed
    always @(posedge core_clk)
    begin
        if (!reset && valid === 1'b1 && rdy === 1'b1)
        begin
            w = exp_q.size() > 0 ? exp_q.pop_front() : 5'bx;
            compare_word(w, {err, data});
        end
        n_end += (fend === 1'b1);
        n_ovf += (ovf === 1'b1);
    end
    initial
    begin
        repeat (5) @(negedge core_clk);
        reset = 1'b0;
        rmode = 2'h1;
        frame(16, 16);
        serial = 1'b1;
        frame(12, 12);
        serial = 1'b0;
        rmode = 2'h2;
        n_ovf = 0;
        // the stalled output stage keeps one word beside the full fifo
        frame(FIFO_DEPTH + 4, FIFO_DEPTH + 1);
        compare_count("overflows", 3, n_ovf);
        compare_count("frame ends", 3, n_end);
        for (int m = 0; m < 4; m++)
        begin
            fdx = m[1];
            col = m[0];
            u_phy.collide(m[0]);
            repeat (6) @(negedge core_clk);
            compare_flag("collision", m == 1, coll);
            compare_flag("carrier", m[0], carr);
        end
        tally_and_finish();
    end
    // cuts a hang short, far beyond the expected run
    initial
    begin
        #200000;
        failures++;
        tally_and_finish();
    end
endmodule
